// [rtl/powerup_config_loader_consts.vh]
// constants for the power-up configuration loader
`ifndef POWERUP_CONFIG_LOADER_CONSTS_VH
`define POWERUP_CONFIG_LOADER_CONSTS_VH
`define CFG_DEPTH         768
`define CFG_AW            10
`define CFG_DW            8
`define CFG_LAST          10'h2ff
`define SLOT_W            2
`define OTP_AW            12
`define CLK_HZ            10000000
`define STRAP_HOLD_MS     125
`define STRAP_HOLD_CYC    ((`CLK_HZ / 1000) * `STRAP_HOLD_MS)
`define STRAP_CNT_W       21
`define GPIO_W            7
`define MCLK_24M576       2'h0
`define MCLK_49M152       2'h1
`define MCLK_20M          2'h2
`define MCLK_RSVD         2'h3
`define OUT_EN_REG        10'h000
`define OUT_EN_DIFF0_BIT  0
`define OUT_W             16
`endif

// [rtl/config_ram.v]
// configuration register image, 768 x 8, registered read
`timescale 1ns/1ps
`include "powerup_config_loader_consts.vh"
module config_ram (
    // clock
    input  wire                 ref_clk,
    // write port
    input  wire                 wr_en,
    input  wire [`CFG_AW-1:0]   wr_addr,
    input  wire [`CFG_DW-1:0]   wr_data,
    // read port
    input  wire [`CFG_AW-1:0]   rd_addr,
    output reg  [`CFG_DW-1:0]   rd_data
);
    reg [`CFG_DW-1:0] mem [0:`CFG_DEPTH-1];

    // no reset on the array: the loader rewrites every location after reset
    always @(posedge ref_clk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
endmodule // config_ram

// [rtl/powerup_config_loader.v]
// power-up strap sampling and configuration image loader
`timescale 1ns/1ps
`include "powerup_config_loader_consts.vh"
// How it works
// - no custom image: load built-in defaults everywhere
// - straps sampled, held 125 ms after release
// - all clock outputs disabled after reset
// - strap pin 2 high enables first differential when the built-in defaults load
// - image is 768 locations of 8 bits
// - custom parts load from one-time-programmable image
// - pins 5,6 select slot, pin 5 high bit
// - host may overwrite registers any time after load
// - host writes volatile, reset reloads the image
// - pin functions set by the loaded image, then by host writes
// - straps 1:0 select master clock frequency
module powerup_config_loader #(
    // strap hold in cycles; a bench may shorten it, the part keeps 125 ms
    parameter HOLD_CYC = `STRAP_HOLD_CYC
) (
    // clock and reset
    input  wire                 ref_clk,
    input  wire                 sys_rst,
    // straps (gpio pins at power-up)
    input  wire [`GPIO_W-1:0]   gpio_in,
    input  wire                 custom_image_en,
    // one-time-programmable image read port
    output reg  [`OTP_AW-1:0]   otp_addr_q,
    output reg                  otp_rd_q,
    input  wire [`CFG_DW-1:0]   otp_data,
    // host register access
    input  wire                 host_wr,
    input  wire                 host_rd,
    input  wire [`CFG_AW-1:0]   host_addr,
    input  wire [`CFG_DW-1:0]   host_wdata,
    output reg  [`CFG_DW-1:0]   host_rdata_q,
    output reg                  host_rvalid_q,
    output reg                  host_ready_q,
    // results
    output reg  [1:0]           mclk_sel_q,
    output reg  [`SLOT_W-1:0]   slot_q,
    output reg                  out_diff0_en_q,
    output reg  [`OUT_W-1:0]    out_en_q,
    output reg                  gpio_release_q,
    output reg                  config_done_q
);
    // loader states, binary coded; the order is the load walk
    localparam ST_STRAP = 3'h0;
    localparam ST_REQ   = 3'h1;
    localparam ST_WAIT  = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_RUN   = 3'h4;

    // last count of the strap window, cut to the counter width on purpose
    localparam integer            HOLD_LAST_I = HOLD_CYC - 1;
    localparam [`STRAP_CNT_W-1:0] HOLD_LAST   = HOLD_LAST_I[`STRAP_CNT_W-1:0];

    // loader state, window counter and load pointer
    reg  [2:0]              state_q;
    reg  [2:0]              state_d;
    reg  [`STRAP_CNT_W-1:0] strap_cnt_q;
    reg  [`CFG_AW-1:0]      ld_addr_q;
    // strap samples that steer the load itself
    reg                     use_otp_q;
    reg                     gpio2_q;
    // byte fetched from the stored image, written one cycle later
    reg  [`CFG_DW-1:0]      ld_data_q;
    // host read in flight between the memory and the read register
    reg                     rd_pend_q;
    // copy of the output-enable word, so the enables need no memory read
    reg  [`CFG_DW-1:0]      en_img_q;
    reg  [`CFG_DW-1:0]      en_img_d;

    // built-in default image; only the output-enable word carries the strap
    function [`CFG_DW-1:0] default_byte;
        input [`CFG_AW-1:0] a;
        input               diff0;
        begin
            default_byte = {`CFG_DW{1'b0}};
            if (a == `OUT_EN_REG)
                default_byte[`OUT_EN_DIFF0_BIT] = diff0;
        end
    endfunction

    // otp address: slot selects one of four 1 KiB windows
    function [`OTP_AW-1:0] otp_addr_of;
        input [`SLOT_W-1:0] s;
        input [`CFG_AW-1:0] a;
        begin
            otp_addr_of = {s, a};
        end
    endfunction

    // true on the last location of the image
    function is_last;
        input [`CFG_AW-1:0] a;
        begin
            is_last = (a == `CFG_LAST);
        end
    endfunction

    // true on the location that holds the output enables
    function is_en_reg;
        input [`CFG_AW-1:0] a;
        begin
            is_en_reg = (a == `OUT_EN_REG);
        end
    endfunction

    // decoded phases of the loader
    wire strap_phase = (state_q == ST_STRAP);
    wire strap_end   = strap_phase && (strap_cnt_q == HOLD_LAST);
    wire load_wr     = (state_q == ST_WRITE);
    wire load_end    = load_wr && is_last(ld_addr_q);
    wire run         = (state_q == ST_RUN);

    // host access only once running; earlier requests are dropped silently
    wire host_wr_ok = run & host_wr;
    wire host_rd_ok = run & host_rd & ~host_wr;

    // byte for the current load location: stored image or defaults
    wire [`CFG_DW-1:0] ld_byte = use_otp_q ? ld_data_q
                                           : default_byte(ld_addr_q, gpio2_q);

    // one write port shared by the loader and the host; the two never overlap
    wire               ram_we    = load_wr | host_wr_ok;
    wire [`CFG_AW-1:0] ram_waddr = load_wr ? ld_addr_q : host_addr;
    wire [`CFG_DW-1:0] ram_wdata = load_wr ? ld_byte : host_wdata;
    wire [`CFG_DW-1:0] ram_rdata;

    // image storage; gpio functions live here and are set by loader writes and host writes
    config_ram u_ram (
        .ref_clk (ref_clk),
        .wr_en   (ram_we),
        .wr_addr (ram_waddr),
        .wr_data (ram_wdata),
        .rd_addr (host_addr),
        .rd_data (ram_rdata)
    );

    // next state: strap window, then three cycles per location, then run
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_STRAP: begin
                if (strap_end)
                    state_d = ST_REQ;
            end
            ST_REQ:   state_d = ST_WAIT;
            ST_WAIT:  state_d = ST_WRITE;
            ST_WRITE: begin
                if (load_end)
                    state_d = ST_RUN;
                else
                    state_d = ST_REQ;
            end
            ST_RUN:   state_d = ST_RUN;
            default:  state_d = ST_STRAP;
        endcase
    end

    // state register; reset always restarts from the strap window
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            state_q <= ST_STRAP;
        else
            state_q <= state_d;
    end

    // strap window counter; stops at its last count
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            strap_cnt_q <= {`STRAP_CNT_W{1'b0}};
        else if (strap_phase && !strap_end)
            strap_cnt_q <= strap_cnt_q + 1'b1;
    end

    // straps are re-sampled every cycle of the window, so the last value
    // before the end of the hold time wins; a strap that moves early is
    // tolerated as long as it settles before the window closes
    // limitation: the reserved clock code is passed on as it is
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mclk_sel_q <= `MCLK_24M576;
            slot_q     <= {`SLOT_W{1'b0}};
            gpio2_q    <= 1'b0;
            use_otp_q  <= 1'b0;
        end else if (strap_phase) begin
            mclk_sel_q <= gpio_in[1:0];
            slot_q     <= {gpio_in[5], gpio_in[6]};
            gpio2_q    <= gpio_in[2];
            use_otp_q  <= custom_image_en;
        end
    end

    // pins go back to ordinary use once the window has closed; their
    // functions then come from the loaded image and from host writes to it
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            gpio_release_q <= 1'b0;
        else if (strap_end)
            gpio_release_q <= 1'b1;
    end

    // load pointer walks 0..767 once; it rests on the last location
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            ld_addr_q <= {`CFG_AW{1'b0}};
        else if (load_wr && !load_end)
            ld_addr_q <= ld_addr_q + 1'b1;
    end

    // stored-image read: the strobe is raised only for custom parts, so a
    // default load never touches the one-time-programmable array
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            otp_addr_q <= {`OTP_AW{1'b0}};
            otp_rd_q   <= 1'b0;
        end else begin
            otp_rd_q <= 1'b0;
            if (state_q == ST_REQ) begin
                otp_addr_q <= otp_addr_of(slot_q, ld_addr_q);
                otp_rd_q   <= use_otp_q;
            end
        end
    end

    // the array answers in the same cycle that the strobe is high; capture it here
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            ld_data_q <= {`CFG_DW{1'b0}};
        else if (state_q == ST_WAIT)
            ld_data_q <= otp_data;
    end

    // done flag rises with the write of the last location
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            config_done_q <= 1'b0;
        else if (load_end)
            config_done_q <= 1'b1;
    end

    // readiness follows the loader so it rises with the done flag
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            host_ready_q <= 1'b0;
        else
            host_ready_q <= run | load_end;
    end

    // host reads: memory read on the taking edge, result one edge later;
    // a write in the same cycle wins and the read is dropped
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_q     <= 1'b0;
            host_rvalid_q <= 1'b0;
            host_rdata_q  <= {`CFG_DW{1'b0}};
        end else begin
            rd_pend_q     <= host_rd_ok;
            host_rvalid_q <= rd_pend_q;
            if (rd_pend_q)
                host_rdata_q <= ram_rdata;
        end
    end

    // next copy of the enable word: the loader's byte, or a host write
    always @* begin
        en_img_d = en_img_q;
        if (load_wr && is_en_reg(ld_addr_q))
            en_img_d = ld_byte;
        else if (host_wr_ok && is_en_reg(host_addr))
            en_img_d = host_wdata;
    end

    // copy of the enable word; it is lost on reset like the rest
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            en_img_q <= {`CFG_DW{1'b0}};
        else
            en_img_q <= en_img_d;
    end

    // outputs stay off until the whole image is in, even though the enable
    // word is location 0 and arrives first; this costs one copy register
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_en_q       <= {`OUT_W{1'b0}};
            out_diff0_en_q <= 1'b0;
        end else if (run | load_end) begin
            out_en_q       <= {{(`OUT_W-`CFG_DW){1'b0}}, en_img_d};
            out_diff0_en_q <= en_img_d[`OUT_EN_DIFF0_BIT];
        end else begin
            out_en_q       <= {`OUT_W{1'b0}};
            out_diff0_en_q <= 1'b0;
        end
    end
endmodule // powerup_config_loader

// [verification/otp_model.sv]
// one-time-programmable image model for the loader's read port
`timescale 1ns/1ps
module otp_model (
    // clock
    input  wire logic        ref_clk,
    // read port
    input  wire logic [11:0] otp_addr_q,
    input  wire logic        otp_rd_q,
    output wire logic [7:0]  otp_data
);
    logic [7:0] junk_q = 8'h5a;
    // outside a read the bus toggles, so a late capture never sees a stale byte
    always @(posedge ref_clk) junk_q <= ~junk_q;
    // byte depends on slot and location, so a wrong slot is caught
    assign otp_data = otp_rd_q ? otp_addr_q[7:0] ^ {otp_addr_q[9:8], otp_addr_q[11:10], 4'h0}
                               : junk_q;
endmodule // otp_model

// [verification/loader_chk_sva.sv]
// port assertions for the power-up configuration loader
`timescale 1ns/1ps
module loader_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // host side
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic        host_rvalid_q,
    input wire logic        host_ready_q,
    // image and results
    input wire logic        otp_rd_q,
    input wire logic [11:0] otp_addr_q,
    input wire logic [1:0]  slot_q,
    input wire logic [15:0] out_en_q,
    input wire logic        gpio_release_q,
    input wire logic        config_done_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic rd_t1, rd_t2;
    // accepted reads carried to the answer slot; a write wins over a read
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) {rd_t2, rd_t1} <= 2'b00;
        else {rd_t2, rd_t1} <= {rd_t1, host_rd && !host_wr && host_ready_q};
    end
    rd_answer_a: assert property (host_rvalid_q == rd_t2) else $error("read timing");
    idle_host_a: assert property (!host_ready_q |-> !host_rvalid_q) else $error("early");
    ready_load_a: assert property (host_ready_q == config_done_q) else $error("ready");
    window_first_a: assert property (config_done_q |-> gpio_release_q) else $error("wnd");
    outs_off_a: assert property (!config_done_q |-> out_en_q == 16'h0000) else $error("on");
    slot_addr_a: assert property (otp_rd_q |-> otp_addr_q[11:10] == slot_q) else $error("sl");
    straps_held_a: assert property ($past(gpio_release_q) |-> $stable(slot_q)) else $error("st");
    otp_quiet_a: assert property (config_done_q |-> !otp_rd_q) else $error("otp");
endmodule // loader_chk
bind powerup_config_loader loader_chk u_chk (.ref_clk, .sys_rst, .host_wr, .host_rd,
    .host_rvalid_q, .host_ready_q, .otp_rd_q, .otp_addr_q, .slot_q, .out_en_q,
    .gpio_release_q, .config_done_q);

// [verification/tb_top.sv]
// self-checking bench for the power-up configuration loader
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0, sys_rst = 1'b1, custom_image_en = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    logic [6:0] gpio_in = 7'h00;
    logic [9:0] host_addr = 10'h000;
    logic [7:0] host_wdata = 8'h00, otp_data, host_rdata_q, got;
    logic [11:0] otp_addr_q;
    logic [1:0] mclk_sel_q, slot_q;
    logic [15:0] out_en_q;
    logic otp_rd_q, host_rvalid_q, host_ready_q, out_diff0_en_q, gpio_release_q, config_done_q;
    int error_cnt = 0, samples_checked = 0;
    logic [9:0] wa [4] = '{10'h001, 10'h17f, 10'h2ff, 10'h001};
    logic [7:0] wd [4] = '{8'h3c, 8'hff, 8'ha5, 8'h00};
    // short strap window keeps the run small; the count logic is the same
    powerup_config_loader #(.HOLD_CYC(200)) DUT (.ref_clk, .sys_rst, .gpio_in, .custom_image_en, .otp_addr_q,
        .otp_rd_q, .otp_data, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata_q,
        .host_rvalid_q, .host_ready_q, .mclk_sel_q, .slot_q, .out_diff0_en_q, .out_en_q,
        .gpio_release_q, .config_done_q);
    otp_model u_otp (.ref_clk, .otp_addr_q, .otp_rd_q, .otp_data);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(negedge ref_clk);
        {host_wr, host_addr, host_wdata} = {1'b1, a, d};
        @(negedge ref_clk);
        host_wr = 1'b0;
    endtask
    // answer lands two edges after the request; the loop bound catches a lost one
    task automatic rd(logic [9:0] a);
        @(negedge ref_clk);
        {host_rd, host_addr} = {1'b1, a};
        @(negedge ref_clk);
        host_rd = 1'b0;
        for (int i = 0; i < 4 && host_rvalid_q !== 1'b1; i++) @(posedge ref_clk) #1;
        got = host_rdata_q;
        if (host_rvalid_q !== 1'b1) begin error_cnt++; finish_test(); end
    endtask
    // straps stay put for the whole window; the early write must be dropped
    task automatic load(logic [6:0] straps, logic cust);
        @(negedge ref_clk);
        {sys_rst, gpio_in, custom_image_en} = {1'b1, straps, cust};
        repeat (5) @(negedge ref_clk);
        chk("reset out_en", 16'h0000, out_en_q);
        sys_rst = 1'b0;
        wr(10'h003, 8'haa);
        for (int i = 0; i < 4000 && config_done_q !== 1'b1; i++) @(negedge ref_clk);
        if (config_done_q !== 1'b1) begin error_cnt++; finish_test(); end
    endtask
    initial begin
        load(7'h26, 1'b0);
        chk("mclk_sel", 16'h0002, mclk_sel_q);
        chk("out_en", 16'h0001, out_en_q);
        chk("diff0_en", 16'h0001, out_diff0_en_q);
        rd(10'h003);
        chk("loc3", 16'h0000, got);
        for (int r = 0; r < 4; r++) begin
            wr(wa[r], wd[r]);
            rd(wa[r]);
            chk("row", wd[r], got);
        end
        wr(10'h000, 8'h04);
        chk("host out_en", 16'h0004, out_en_q);
        chk("host diff0", 16'h0000, out_diff0_en_q);
        rd(10'h000);
        chk("loc0", 16'h0004, got);
        $display("test defaults done");
        load(7'h41, 1'b1);
        chk("slot", 16'h0001, slot_q);
        chk("mclk custom", 16'h0001, mclk_sel_q);
        chk("diff0 custom", 16'h0000, out_diff0_en_q);
        chk("out_en custom", 16'h0010, out_en_q);
        rd(10'h001);
        chk("loc1 reload", 16'h0011, got);
        rd(10'h2ff);
        chk("last loc", 16'h006f, got);
        $display("test custom done");
        finish_test();
    end
endmodule // tb_top
